//--- dprka_core.v
`timescale 1ns/1ps
`include "dprka_consts.vh"

module dprka_core #(
	parameter [7:0]   RESET_SIG = 8'h5a,              // Arbitrary value
	parameter [127:0] SIB_VALUE = "FAMILY00 P0:V0 0" // Arbitrary value
) (
	input  wire        clk_sys,
	input  wire        rstn,
	input  wire        port_disable,
	input  wire        prog_done,
	input  wire        lock_in,
	input  wire        in_sleep,
	input  wire        rx_valid,
	input  wire [7:0]  rx_data,
	input  wire        rx_break,
	output wire        tx_valid,
	output wire [7:0]  tx_data,
	output wire        tx_guard,
	output wire [2:0]  tx_idle_bits,
	input  wire        tx_ready,
	output wire        sbus_req,
	output wire        sbus_we,
	output wire [15:0] sbus_addr,
	output wire [7:0]  sbus_wdata,
	input  wire [7:0]  sbus_rdata,
	input  wire        sbus_ack,
	output wire        sys_reset_req,
	output wire        erase_start,
	output wire        flash_prog_en,
	output wire        urow_prog_en,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	output wire [1:0]  s_axi_bresp,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	input  wire [7:0]  s_axi_araddr,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp
);

	localparam [3:0] S_SYNC = 4'd0;
	localparam [3:0] S_OPC  = 4'd1;
	localparam [3:0] S_ADDR = 4'd2;
	localparam [3:0] S_AACK = 4'd3;
	localparam [3:0] S_WDAT = 4'd4;
	localparam [3:0] S_BUS  = 4'd5;
	localparam [3:0] S_TX   = 4'd6;
	localparam [3:0] S_WACK = 4'd7;
	localparam [3:0] S_KEY  = 4'd8;
	localparam [3:0] S_RPT  = 4'd9;
	localparam [3:0] S_NEXT = 4'd10;
	localparam [7:0] PHY_CONTROL_SECOND_REG_RST = `DPRKA_PHY_CONTROL_SECOND_REG_RESET;

	// ****************************************
	// Instruction state
	// ****************************************
	reg [3:0]  state_q;
	reg [7:0]  op_q;
	reg [4:0]  bidx_q;
	reg [15:0] addr_q;
	reg [15:0] ptr_q;
	reg [15:0] wd_q;
	reg [7:0]  rd_q;
	reg [63:0] key_sh_q;
	reg [7:0]  rpt_q;
	reg [7:0]  rpt_left_q;
	reg        rpt_arm_q;
	reg        rpt_act_q;
	reg        first_q;

	// ****************************************
	// Control space registers
	// ****************************************
	reg        gap_en_q;
	reg [7:0]  rstreq_q;
	reg        key_erase_q;
	reg        key_prog_q;
	reg        key_urow_q;
	reg        prog_flag_q;
	reg        urow_flag_q;
	reg        erase_start_q;

	wire [2:0]  opc      = op_q[7:5];
	wire [1:0]  f32      = op_q[3:2];
	wire [1:0]  f10      = op_q[1:0];
	wire        is_ptr   = (opc == `DPRKA_OP_LD || opc == `DPRKA_OP_ST) && f32 == `DPRKA_PTR_REG;
	wire        is_store = opc == `DPRKA_OP_STS || opc == `DPRKA_OP_ST;
	wire        direct   = opc == `DPRKA_OP_LDS || opc == `DPRKA_OP_STS;
	wire [4:0]  na       = (f32 == 2'b01) ? 5'd2 : 5'd1;
	wire [4:0]  nb       = (opc == `DPRKA_OP_KEY) ? ((f10 == 2'b00) ? 5'd8 : 5'd16) :
		(opc == `DPRKA_OP_REPEAT || opc == `DPRKA_OP_LDCS || opc == `DPRKA_OP_STCS) ? 5'd1 :
		((f10 == 2'b01) ? 5'd2 : 5'd1);
	wire        last_b   = (bidx_q + 5'd1) == nb;
	wire [15:0] base     = direct ? addr_q : ptr_q;
	wire        tx_in_v  = state_q == S_AACK || state_q == S_WACK || state_q == S_TX;
	wire        tx_in_r;
	wire        tx_take  = tx_in_v && tx_in_r;
	wire        rst_act  = rstreq_q == RESET_SIG;
	wire [63:0] key_full = {rx_data, key_sh_q[63:8]};
	wire        key_done = state_q == S_KEY && rx_valid && last_b && f10 == 2'b00;
	reg  [7:0]  tx_byte;

	function [3:0] entry;
		input [7:0] op;
		begin
			case (op[7:5])
				`DPRKA_OP_LDS, `DPRKA_OP_STS: entry = S_ADDR;
				`DPRKA_OP_LD:   entry = (op[3:2] == `DPRKA_PTR_REG) ? S_TX : S_BUS;
				`DPRKA_OP_LDCS: entry = S_TX;
				`DPRKA_OP_REPEAT: entry = S_RPT;
				`DPRKA_OP_KEY:  entry = op[`DPRKA_SIB_BIT] ? S_TX : S_KEY;
				default:        entry = S_WDAT;
			endcase
		end
	endfunction

	function [7:0] cs_read;
		input [5:0] idx;
		begin
			if (idx == `DPRKA_IDX_PHY_CONTROL_SECOND_REG)
				cs_read = {gap_en_q, 7'h00};
			else if (idx == `DPRKA_IDX_KEY)
				cs_read = {2'b00, key_urow_q, key_prog_q, key_erase_q, 3'b000};
			else if (idx == `DPRKA_IDX_RSTREQ)
				cs_read = rstreq_q;
			else if (idx == `DPRKA_IDX_SYS)
				cs_read = {2'b00, rst_act, in_sleep, prog_flag_q, urow_flag_q, 1'b0, lock_in};
			else if (idx == `DPRKA_IDX_RPT)
				cs_read = rpt_q;
			else
				cs_read = 8'h00;
		end
	endfunction

	function cs_hit;
		input [5:0] idx;
		begin
			cs_hit = idx == `DPRKA_IDX_PHY_CONTROL_SECOND_REG || idx == `DPRKA_IDX_KEY ||
				idx == `DPRKA_IDX_RSTREQ || idx == `DPRKA_IDX_SYS || idx == `DPRKA_IDX_RPT;
		end
	endfunction

	// ****************************************
	// Output byte selection
	// ****************************************
	always @* begin
		tx_byte = `DPRKA_ACK_CHAR;
		if (state_q == S_TX) begin
			if (opc == `DPRKA_OP_KEY)
				tx_byte = SIB_VALUE[127 - 8 * bidx_q -: 8];
			else if (opc == `DPRKA_OP_LDCS)
				tx_byte = cs_read({2'b00, op_q[3:0]});
			else if (is_ptr)
				tx_byte = bidx_q[0] ? ptr_q[15:8] : ptr_q[7:0];
			else
				tx_byte = rd_q;
		end
	end

	// Locked part never raises a bus request
	assign sbus_req   = state_q == S_BUS && !lock_in;
	assign sbus_we    = is_store;
	assign sbus_addr  = base + {11'h000, bidx_q};
	assign sbus_wdata = bidx_q[0] ? wd_q[15:8] : wd_q[7:0];

	// ****************************************
	// Instruction sequencer
	// ****************************************
	always @(posedge clk_sys) begin
		if (!rstn) begin
			state_q    <= S_SYNC;
			op_q       <= 8'h00;
			bidx_q     <= 5'd0;
			addr_q     <= 16'h0000;
			ptr_q      <= 16'h0000;
			wd_q       <= 16'h0000;
			rd_q       <= 8'h00;
			key_sh_q   <= 64'h0;
			rpt_q      <= `DPRKA_RPT_RESET;
			rpt_left_q <= 8'h00;
			rpt_arm_q  <= 1'b0;
			rpt_act_q  <= 1'b0;
		end else if (rx_break) begin
			state_q   <= S_SYNC;
			bidx_q    <= 5'd0;
			rpt_arm_q <= 1'b0;
			rpt_act_q <= 1'b0;
		end else begin
			case (state_q)
				S_SYNC: begin
					bidx_q <= 5'd0;
					if (rx_valid && rx_data == `DPRKA_SYNC_CHAR)
						state_q <= S_OPC;
				end
				S_OPC: if (rx_valid) begin
					op_q    <= rx_data;
					state_q <= entry(rx_data);
					if (rx_data[7:5] == `DPRKA_OP_REPEAT) begin
						rpt_act_q <= 1'b0;
					end else if (rpt_arm_q) begin
						rpt_arm_q  <= 1'b0;
						rpt_act_q  <= 1'b1;
						rpt_left_q <= rpt_q;
					end
				end
				S_ADDR: if (rx_valid) begin
					if (bidx_q == 5'd0)
						addr_q <= {8'h00, rx_data};
					else
						addr_q[15:8] <= rx_data;
					bidx_q <= bidx_q + 5'd1;
					if ((bidx_q + 5'd1) == na) begin
						bidx_q  <= 5'd0;
						state_q <= is_store ? S_AACK : S_BUS;
					end
				end
				S_AACK: if (tx_take)
					state_q <= S_WDAT;
				S_WDAT: if (rx_valid) begin
					if (bidx_q == 5'd0)
						wd_q <= {8'h00, rx_data};
					else
						wd_q[15:8] <= rx_data;
					bidx_q <= bidx_q + 5'd1;
					if (last_b) begin
						bidx_q <= 5'd0;
						if (opc == `DPRKA_OP_STCS)
							state_q <= S_NEXT;
						else if (is_ptr)
							state_q <= S_WACK;
						else
							state_q <= S_BUS;
						if (is_ptr)
							ptr_q <= (f10 == 2'b01) ? {rx_data, wd_q[7:0]} : {8'h00, rx_data};
					end
				end
				S_BUS: if (lock_in) begin
					// Denied access: loads read zero, stores get no ack
					rd_q    <= 8'h00;
					state_q <= is_store ? S_NEXT : S_TX;
				end else if (sbus_ack) begin
					rd_q <= sbus_rdata;
					if (!is_store)
						state_q <= S_TX;
					else if (last_b) begin
						bidx_q  <= 5'd0;
						state_q <= S_WACK;
					end else
						bidx_q <= bidx_q + 5'd1;
				end
				S_TX: if (tx_take) begin
					bidx_q <= bidx_q + 5'd1;
					if (last_b)
						state_q <= S_NEXT;
					else if (!is_ptr && (opc == `DPRKA_OP_LD || opc == `DPRKA_OP_LDS))
						state_q <= S_BUS;
				end
				S_WACK: if (tx_take)
					state_q <= S_NEXT;
				S_KEY: if (rx_valid) begin
					key_sh_q <= key_full;
					bidx_q   <= bidx_q + 5'd1;
					if (last_b)
						state_q <= S_NEXT;
				end
				S_RPT: if (rx_valid) begin
					rpt_q     <= rx_data;
					rpt_arm_q <= 1'b1;
					state_q   <= S_SYNC;
				end
				default: begin
					bidx_q <= 5'd0;
					if (!is_ptr && !direct && f32 == `DPRKA_PTR_INC &&
						(opc == `DPRKA_OP_LD || opc == `DPRKA_OP_ST))
						ptr_q <= ptr_q + {11'h000, nb};
					if (rpt_act_q && rpt_left_q != 8'h00) begin
						rpt_left_q <= rpt_left_q - 8'h01;
						state_q    <= entry(op_q);
					end else begin
						rpt_act_q <= 1'b0;
						state_q   <= S_SYNC;
					end
				end
			endcase
		end
	end

	// First output byte after any received byte is a turnaround
	always @(posedge clk_sys) begin
		if (!rstn)
			first_q <= 1'b1;
		else if (rx_valid)
			first_q <= 1'b1;
		else if (tx_take)
			first_q <= 1'b0;
	end

	dprka_tx_pace u_pace (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.gap_en       (gap_en_q),
		.in_valid     (tx_in_v),
		.in_data      (tx_byte),
		.in_first     (first_q),
		.in_ready     (tx_in_r),
		.tx_valid     (tx_valid),
		.tx_data      (tx_data),
		.tx_guard     (tx_guard),
		.tx_idle_bits (tx_idle_bits),
		.tx_ready     (tx_ready)
	);

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	reg        aw_held_q;
	reg [7:0]  awaddr_q;
	reg        w_held_q;
	reg [31:0] wdata_q;
	reg [3:0]  wstrb_q;
	reg        bvalid_q;
	reg [1:0]  bresp_q;
	reg        rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0]  rresp_q;

	wire       wr_fire = aw_held_q && w_held_q && !bvalid_q;
	wire [5:0] wr_idx  = awaddr_q[7:2];
	wire       wr_lane = wr_fire && wstrb_q[0];
	wire       wr_rst  = wr_lane && wr_idx == `DPRKA_IDX_RSTREQ;
	wire       rst_clear = wr_rst && wdata_q[7:0] == 8'h00 && rst_act;

	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always @(posedge clk_sys) begin
		if (!rstn) begin
			aw_held_q <= 1'b0;
			awaddr_q  <= 8'h00;
			w_held_q  <= 1'b0;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `DPRKA_RESP_OKAY;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= `DPRKA_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= cs_hit(wr_idx) ? `DPRKA_RESP_OKAY : `DPRKA_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_q <= 1'b1;
				rdata_q  <= {24'h000000, cs_read(s_axi_araddr[7:2])};
				rresp_q  <= cs_hit(s_axi_araddr[7:2]) ? `DPRKA_RESP_OKAY : `DPRKA_RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Keys, reset request and status flags
	// ****************************************
	always @(posedge clk_sys) begin
		if (!rstn) begin
			gap_en_q      <= PHY_CONTROL_SECOND_REG_RST[`DPRKA_GAP_EN_BIT];
			rstreq_q      <= `DPRKA_RSTREQ_RESET;
			key_erase_q   <= 1'b0;
			key_prog_q    <= 1'b0;
			key_urow_q    <= 1'b0;
			prog_flag_q   <= 1'b0;
			urow_flag_q   <= 1'b0;
			erase_start_q <= 1'b0;
		end else begin
			if (wr_lane && wr_idx == `DPRKA_IDX_PHY_CONTROL_SECOND_REG)
				gap_en_q <= wdata_q[`DPRKA_GAP_EN_BIT];
			if (wr_rst)
				rstreq_q <= wdata_q[7:0];
			// Clears first so a key landing in the same cycle wins
			if (port_disable)
				key_erase_q <= 1'b0;
			if (prog_done)
				key_prog_q <= 1'b0;
			if (wr_lane && wr_idx == `DPRKA_IDX_KEY && wdata_q[`DPRKA_KEY_UROW_BIT])
				key_urow_q <= 1'b0;
			// Each key only sets its own bit, others stay as they are
			if (key_done && key_full == `DPRKA_KEY_ERASE)
				key_erase_q <= 1'b1;
			if (key_done && key_full == `DPRKA_KEY_PROG)
				key_prog_q <= 1'b1;
			if (key_done && key_full == `DPRKA_KEY_UROW)
				key_urow_q <= 1'b1;
			erase_start_q <= rst_clear && key_erase_q;
			if (!key_prog_q)
				prog_flag_q <= 1'b0;
			else if (rst_clear && !lock_in)
				prog_flag_q <= 1'b1;
			if (!key_urow_q)
				urow_flag_q <= 1'b0;
			else if (rst_clear && lock_in)
				urow_flag_q <= 1'b1;
		end
	end

	assign sys_reset_req = rst_act;
	assign erase_start   = erase_start_q;
	assign flash_prog_en = prog_flag_q;
	assign urow_prog_en  = urow_flag_q;

endmodule

//--- dprka_consts.vh
`ifndef DPRKA_CONSTS_VH
`define DPRKA_CONSTS_VH

// ****************************************
// Link characters
// ****************************************
`define DPRKA_SYNC_CHAR     8'h55
`define DPRKA_ACK_CHAR      8'h40

// ****************************************
// Opcode classes, opcode bits 7:5
// ****************************************
`define DPRKA_OP_LDS        3'h0
`define DPRKA_OP_LD         3'h1
`define DPRKA_OP_STS        3'h2
`define DPRKA_OP_ST         3'h3
`define DPRKA_OP_LDCS       3'h4
`define DPRKA_OP_REPEAT     3'h5
`define DPRKA_OP_STCS       3'h6
`define DPRKA_OP_KEY        3'h7
`define DPRKA_PTR_REG       2'h2
`define DPRKA_PTR_INC       2'h1
`define DPRKA_SIB_BIT       2

// ****************************************
// Register indices, byte address is four times the index
// ****************************************
`define DPRKA_IDX_PHY_CONTROL_SECOND_REG     6'h03
`define DPRKA_IDX_KEY       6'h07
`define DPRKA_IDX_RSTREQ    6'h08
`define DPRKA_IDX_SYS       6'h0b
`define DPRKA_IDX_RPT       6'h0d

// ****************************************
// Field positions and reset values
// ****************************************
`define DPRKA_GAP_EN_BIT    7
`define DPRKA_KEY_ERASE_BIT 3
`define DPRKA_KEY_PROG_BIT  4
`define DPRKA_KEY_UROW_BIT  5
`define DPRKA_SYS_LOCK_BIT  0
`define DPRKA_SYS_UROW_BIT  2
`define DPRKA_SYS_PROG_BIT  3
`define DPRKA_SYS_SLEEP_BIT 4
`define DPRKA_SYS_RST_BIT   5
`define DPRKA_PHY_CONTROL_SECOND_REG_RESET   8'h00
`define DPRKA_RSTREQ_RESET  8'h00
`define DPRKA_RPT_RESET     8'h00

// ****************************************
// Keys and output idle bits
// ****************************************
`define DPRKA_KEY_ERASE     64'h4e564d4572617365
`define DPRKA_KEY_PROG      64'h4e564d50726f6720
`define DPRKA_KEY_UROW      64'h4e564d5573267465
`define DPRKA_IDLE_BASE     3'h2
`define DPRKA_IDLE_GAP      3'h4

// ****************************************
// AXI responses
// ****************************************
`define DPRKA_RESP_OKAY     2'b00
`define DPRKA_RESP_SLVERR   2'b10

`endif

//--- dprka_tx_pace.v
`timescale 1ns/1ps
`include "dprka_consts.vh"

module dprka_tx_pace (
	input  wire       clk_sys,
	input  wire       rstn,
	input  wire       gap_en,
	input  wire       in_valid,
	input  wire [7:0] in_data,
	input  wire       in_first,
	output wire       in_ready,
	output wire       tx_valid,
	output wire [7:0] tx_data,
	output wire       tx_guard,
	output wire [2:0] tx_idle_bits,
	input  wire       tx_ready
);

	reg       valid_q;
	reg [7:0] data_q;
	reg       guard_q;
	reg [2:0] idle_q;

	assign in_ready     = !valid_q || tx_ready;
	assign tx_valid     = valid_q;
	assign tx_data      = data_q;
	assign tx_guard     = guard_q;
	assign tx_idle_bits = idle_q;

	always @(posedge clk_sys) begin
		if (!rstn) begin
			valid_q <= 1'b0;
			data_q  <= 8'h00;
			guard_q <= 1'b0;
			idle_q  <= 3'h0;
		end else if (in_valid && in_ready) begin
			valid_q <= 1'b1;
			data_q  <= in_data;
			// First byte after turnaround waits the guard time only
			guard_q <= in_first;
			if (in_first)
				idle_q <= 3'h0;
			else if (gap_en)
				idle_q <= `DPRKA_IDLE_GAP;
			else
				idle_q <= `DPRKA_IDLE_BASE;
		end else if (tx_ready) begin
			valid_q <= 1'b0;
		end
	end

endmodule

//--- dprka_chk_asserts.sv
`timescale 1ns/1ps
module dprka_chk (
	input wire		clk_sys,
	input wire		rstn,
	input wire		lock_in,
	input wire		rx_valid,
	input wire		tx_valid,
	input wire [7:0]	tx_data,
	input wire		tx_guard,
	input wire [2:0]	tx_idle_bits,
	input wire		tx_ready,
	input wire		sbus_req,
	input wire		sbus_ack,
	input wire [15:0]	sbus_addr,
	input wire		s_axi_awready,
	input wire		s_axi_bvalid,
	input wire		s_axi_bready,
	input wire [1:0]	s_axi_bresp,
	input wire		s_axi_rvalid,
	input wire		s_axi_rready,
	input wire [31:0]	s_axi_rdata
);
	// ****
	// Byte received since the last byte sent
	// ****
	reg	seen_q;
	always @(posedge clk_sys) begin
		if (!rstn) begin
			seen_q <= 1'b0;
		end else if (rx_valid) begin
			seen_q <= 1'b1;
		end else if (tx_valid && tx_ready) begin
			seen_q <= 1'b0;
		end
	end
	default clocking dck @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response changed before taken");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken while response pending");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_data, tx_idle_bits}))
		else $error("output byte changed before taken");
	a_idle_kind: assert property (tx_valid |-> (tx_guard ? tx_idle_bits == 3'h0 : (tx_idle_bits == 3'h2 || tx_idle_bits == 3'h4)))
		else $error("wrong idle bit count");
	a_guard_first: assert property (tx_valid && seen_q |-> tx_guard && tx_idle_bits == 3'h0)
		else $error("first byte after turnaround lacks guard");
	a_locked_nobus: assert property (lock_in |-> !sbus_req)
		else $error("system bus used while locked");
	a_bus_hold: assert property (sbus_req && !sbus_ack |=> sbus_req && $stable(sbus_addr))
		else $error("bus request dropped before ack");
	cover property (tx_valid && tx_idle_bits == 3'h4);
	cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
	cover property (sbus_req && sbus_ack);
endmodule

//--- dprka_host.sv
`timescale 1ns/1ps
module dprka_host (
	input  wire		clk_sys,
	output reg		rx_valid,
	output reg [7:0]	rx_data,
	output reg		rx_break,
	input  wire		tx_valid,
	input  wire [7:0]	tx_data,
	input  wire		tx_guard,
	input  wire [2:0]	tx_idle_bits,
	output reg		tx_ready,
	input  wire		slow
);
	reg [7:0]	cap_d [0:31];
	reg		cap_g [0:31];
	reg [2:0]	cap_i [0:31];
	integer		cap_n;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_break = 1'b0;
		tx_ready = 1'b0;
		cap_n = 0;
	end
	// ****
	// Slow debugger takes a byte every other cycle
	// ****
	always @(posedge clk_sys) begin
		if (tx_valid && tx_ready) begin
			cap_d[cap_n[4:0]] <= tx_data;
			cap_g[cap_n[4:0]] <= tx_guard;
			cap_i[cap_n[4:0]] <= tx_idle_bits;
			cap_n <= cap_n + 1;
		end
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
	// Line idles at the inverse so stale data never looks valid
	task send(input [7:0] b);
		begin
			rx_valid <= 1'b1;
			rx_data <= b;
			@(posedge clk_sys);
			rx_valid <= 1'b0;
			rx_data <= ~b;
			repeat (7) @(posedge clk_sys);
		end
	endtask
	task brk;
		begin
			rx_break <= 1'b1;
			@(posedge clk_sys);
			rx_break <= 1'b0;
			repeat (7) @(posedge clk_sys);
		end
	endtask
endmodule

//--- dprka_tb_top.sv
`timescale 1ns/1ps
`include "dprka_consts.vh"
module dprka_tb_top;
	localparam [7:0]	SIG = 8'h5a;
	localparam [127:0]	SYSTEM_INFO_BLOCK = "FAMX0000 P1:V1 1"; // Arbitrary value
	reg		clk_sys, rstn, port_disable, prog_done, lock_in, in_sleep, slow, sbus_ack;
	reg [7:0]	sbus_rdata, s_axi_awaddr, s_axi_araddr;
	reg		s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg [31:0]	s_axi_wdata;
	reg [3:0]	s_axi_wstrb;
	reg [15:0]	wlog;
	wire		rx_valid, rx_break, tx_valid, tx_guard, tx_ready, sbus_req, sbus_we;
	wire [7:0]	rx_data, tx_data, sbus_wdata;
	wire [2:0]	tx_idle_bits;
	wire [15:0]	sbus_addr;
	wire		sys_reset_req, erase_start, flash_prog_en, urow_prog_en;
	wire		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]	s_axi_bresp, s_axi_rresp;
	wire [31:0]	s_axi_rdata;
	integer		failures, tests_run, n_erase, base, i;
	dprka_core #(.RESET_SIG(SIG), .SIB_VALUE(SYSTEM_INFO_BLOCK)) dprka_core_inst (.*);
	dprka_host dprka_host_inst (.*);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		#500000;
		failures = failures + 1;
		test_done;
	end
	// ****
	// System bus responder, one-cycle ack
	// ****
	always @(posedge clk_sys) begin
		sbus_ack <= sbus_req & ~sbus_ack;
		sbus_rdata <= sbus_ack ? ~sbus_rdata : sbus_addr[7:0] ^ 8'h3c;
		if (sbus_req && sbus_we && !sbus_ack) wlog <= {sbus_addr[7:0], sbus_wdata};
		if (erase_start) n_erase <= n_erase + 1;
	end
	task chk(input [95:0] nm, input [31:0] exp, input [31:0] got);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("ERROR %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d, input [1:0] er);
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h0, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			do begin
				@(posedge clk_sys);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
			s_axi_bready <= 1'b1;
			do @(posedge clk_sys); while (!s_axi_bvalid);
			s_axi_bready <= 1'b0;
			chk("bresp", er, s_axi_bresp);
		end
	endtask
	task rd(input [7:0] a, input [7:0] d, input [1:0] er);
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			do @(posedge clk_sys); while (!s_axi_arready);
			s_axi_arvalid <= 1'b0;
			repeat (2) @(posedge clk_sys);
			s_axi_rready <= 1'b1;
			do @(posedge clk_sys); while (!s_axi_rvalid);
			s_axi_rready <= 1'b0;
			chk("rdata", {24'h0, d}, s_axi_rdata);
			chk("rresp", er, s_axi_rresp);
		end
	endtask
	task snd(input [7:0] b);
		dprka_host_inst.send(b);
	endtask
	task key(input [7:0] op, input [63:0] k, input integer n);
		begin
			snd(`DPRKA_SYNC_CHAR);
			snd(op);
			for (i = 0; i < n; i = i + 1) snd(k[8 * (i % 8) +: 8]);
		end
	endtask
	task wait_tx(input integer n);
		integer t;
		begin
			t = 0;
			while (dprka_host_inst.cap_n < base + n && t < 3000) begin
				@(posedge clk_sys);
				t = t + 1;
			end
			if (t >= 3000) chk("tx timeout", 0, 1);
		end
	endtask
	task txchk(input integer k, input [7:0] d, input [2:0] idl);
		begin
			chk("tx data", d, dprka_host_inst.cap_d[(base + k) % 32]);
			chk("tx idle", idl, dprka_host_inst.cap_i[(base + k) % 32]);
			chk("tx guard", idl == 3'h0, dprka_host_inst.cap_g[(base + k) % 32]);
		end
	endtask
	task pulse_dis(input sel);
		begin
			if (sel) port_disable <= 1'b1;
			else prog_done <= 1'b1;
			@(posedge clk_sys);
			port_disable <= 1'b0;
			prog_done <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", tests_run, failures);
			if (failures == 0 && tests_run > 0) begin
				$display("TEST PASSED");
			end else begin
				$display("TEST FAILED");
			end
			$finish;
		end
	endtask
	initial begin
		{failures, tests_run, n_erase} = 0;
		{rstn, port_disable, prog_done, lock_in, in_sleep, slow, sbus_ack} = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{sbus_rdata, s_axi_awaddr, s_axi_araddr, s_axi_wdata, wlog} = 0;
		s_axi_wstrb = 4'hf;
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(8'h0c, 8'h00, 2'b00);
		rd(8'h1c, 8'h00, 2'b00);
		rd(8'h20, 8'h00, 2'b00);
		rd(8'h34, 8'h00, 2'b00);
		rd(8'h10, 8'h00, 2'b10);
		wr(8'h10, 8'hff, 2'b10);
		$display("register test done");
		// Whole info block to a stalling debugger, then family code with gap
		slow <= 1'b1;
		base = dprka_host_inst.cap_n;
		key(8'he5, 64'h0, 0);
		wait_tx(16);
		for (i = 0; i < 16; i = i + 1) txchk(i, SYSTEM_INFO_BLOCK[127 - 8 * i -: 8], i ? 3'h2 : 3'h0);
		slow <= 1'b0;
		wr(8'h0c, 8'h80, 2'b00);
		base = dprka_host_inst.cap_n;
		key(8'he4, 64'h0, 0);
		wait_tx(8);
		for (i = 0; i < 8; i = i + 1) txchk(i, SYSTEM_INFO_BLOCK[127 - 8 * i -: 8], i ? 3'h4 : 3'h0);
		wr(8'h0c, 8'h00, 2'b00);
		$display("info block test done");
		// Three direct loads from one repeat, address resent each time
		key(8'ha0, 64'h2, 1);
		rd(8'h34, 8'h02, 2'b00);
		base = dprka_host_inst.cap_n;
		key(8'h00, 64'h11, 1);
		wait_tx(1);
		snd(8'h22);
		wait_tx(2);
		snd(8'h33);
		wait_tx(3);
		for (i = 0; i < 3; i = i + 1) txchk(i, (8'h11 * (i + 1)) ^ 8'h3c, 3'h0);
		snd(8'h44);
		repeat (40) @(posedge clk_sys);
		chk("bytes out", base + 3, dprka_host_inst.cap_n);
		key(8'ha0, 64'hff, 1);
		rd(8'h34, 8'hff, 2'b00);
		key(8'h00, 64'h10, 1);
		wait_tx(4);
		dprka_host_inst.brk;
		snd(8'h20);
		repeat (40) @(posedge clk_sys);
		chk("bytes out", base + 4, dprka_host_inst.cap_n);
		$display("repeat test done");
		key(8'he1, `DPRKA_KEY_ERASE, 16);
		rd(8'h1c, 8'h00, 2'b00);
		key(8'he0, `DPRKA_KEY_PROG, 8);
		key(8'he0, `DPRKA_KEY_ERASE, 8);
		rd(8'h1c, 8'h18, 2'b00);
		key(8'he0, `DPRKA_KEY_UROW, 8);
		rd(8'h1c, 8'h38, 2'b00);
		chk("bytes out", base + 4, dprka_host_inst.cap_n);
		wr(8'h1c, 8'h20, 2'b00);
		rd(8'h1c, 8'h18, 2'b00);
		pulse_dis(1'b1);
		rd(8'h1c, 8'h10, 2'b00);
		pulse_dis(1'b0);
		rd(8'h1c, 8'h00, 2'b00);
		$display("key test done");
		lock_in <= 1'b1;
		key(8'h00, 64'h12, 1);
		wait_tx(5);
		txchk(4, 8'h00, 3'h0);
		key(8'he0, `DPRKA_KEY_ERASE, 8);
		key(8'he0, `DPRKA_KEY_UROW, 8);
		wr(8'h20, SIG, 2'b00);
		chk("sys reset", 1, sys_reset_req);
		rd(8'h2c, 8'h21, 2'b00);
		wr(8'h20, 8'h00, 2'b00);
		chk("sys reset", 0, sys_reset_req);
		@(posedge clk_sys);
		chk("erase start", 1, n_erase);
		chk("urow enable", 1, urow_prog_en);
		lock_in <= 1'b0;
		key(8'he0, `DPRKA_KEY_PROG, 8);
		wr(8'h20, SIG, 2'b00);
		wr(8'h20, 8'h00, 2'b00);
		rd(8'h2c, 8'h0c, 2'b00);
		chk("prog enable", 1, flash_prog_en);
		base = dprka_host_inst.cap_n;
		key(8'h40, 64'h30, 1);
		wait_tx(1);
		snd(8'h5a);
		wait_tx(2);
		txchk(0, `DPRKA_ACK_CHAR, 3'h0);
		txchk(1, `DPRKA_ACK_CHAR, 3'h0);
		chk("bus write", 16'h305a, wlog);
		// Pointer write, then two post-increment loads from one repeat
		base = dprka_host_inst.cap_n;
		key(8'h68, 64'h40, 1);
		key(8'ha0, 64'h1, 1);
		key(8'h24, 64'h0, 0);
		wait_tx(3);
		txchk(0, `DPRKA_ACK_CHAR, 3'h0);
		txchk(1, 8'h40 ^ 8'h3c, 3'h0);
		txchk(2, 8'h41 ^ 8'h3c, 3'h2);
		$display("erase and program test done");
		test_done;
	end
endmodule
bind dprka_core dprka_chk dprka_chk_inst (.*);
